// ==== doms_mode_selector.v ====
/*
 * Operation mode selector of a motor drive: chooses the source of start,
 * direction and frequency commands, with an AHB-Lite register port.
 * Assumes pins and keys are asynchronous levels, keys held at least three
 * clocks, and a single AHB master issuing single word transfers.
 */
`default_nettype none
`include "doms_map.vh"

module doms_mode_selector #(
   parameter FW = 16
) (
   input wire clk,
   input wire rst_b,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire forwardStartInput,
   input wire reverseStartInput,
   input wire currentInputSelect,
   input wire multiSpeedActive,
   input wire inchingInput,
   input wire [FW-1:0] analogVoltageFreq,
   input wire [FW-1:0] analogCurrentFreq,
   input wire [FW-1:0] multiSpeedFreq,
   input wire [FW-1:0] inchingFreq,
   input wire panelToggleKey,
   input wire panelRunKey,
   input wire panelStopKey,
   input wire panelReverseKey,
   output reg [1:0] opMode,
   output reg runCmd,
   output reg reverseCmd,
   output reg [FW-1:0] freqCmd
);

   // Pin synchronisers: stage one feeds stage two only
   localparam NS = 9;
   localparam NF = 4 * FW;
   wire [NS-1:0] pinRaw = {forwardStartInput, reverseStartInput, currentInputSelect, multiSpeedActive,
      inchingInput, panelToggleKey, panelRunKey, panelStopKey, panelReverseKey};
   wire [NF-1:0] freqRaw = {analogVoltageFreq, analogCurrentFreq, multiSpeedFreq, inchingFreq};
   reg [NS-1:0] pinMeta;
   reg [NS-1:0] pinSync;
   reg [NF-1:0] freqMeta;
   reg [NF-1:0] freqSync;
   reg [3:0] keyLast;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pinMeta <= {NS{1'b0}};
         pinSync <= {NS{1'b0}};
         freqMeta <= {NF{1'b0}};
         freqSync <= {NF{1'b0}};
         keyLast <= 4'h0;
      end else begin
         pinMeta <= pinRaw;
         pinSync <= pinMeta;
         freqMeta <= freqRaw;
         freqSync <= freqMeta;
         keyLast <= pinSync[3:0];
      end
   end

   wire fwdIn = pinSync[8];
   wire revIn = pinSync[7];
   wire curSel = pinSync[6];
   wire msActive = pinSync[5];
   wire inchIn = pinSync[4];
   // Key presses act on the synchronised rising edge
   wire toggleEdge = pinSync[3] & ~keyLast[3];
   wire runEdge = pinSync[2] & ~keyLast[2];
   wire stopEdge = pinSync[1] & ~keyLast[1];
   wire revEdge = pinSync[0] & ~keyLast[0];
   wire [FW-1:0] voltFreq = freqSync[4*FW-1:3*FW];
   wire [FW-1:0] curFreq = freqSync[3*FW-1:2*FW];
   wire [FW-1:0] msFreq = freqSync[2*FW-1:FW];
   wire [FW-1:0] inchFreq = freqSync[FW-1:0];

   // Settings accepted by a control write
   function legalSetting;
      input [2:0] s;
      begin
         legalSetting = (s == `DOMS_SET_SWITCH) || (s == `DOMS_SET_PANEL) || (s == `DOMS_SET_EXT) ||
            (s == `DOMS_SET_COMB1) || (s == `DOMS_SET_COMB2) || (s == `DOMS_SET_RUNSWITCH);
      end
   endfunction

   // Register state
   reg [2:0] modeSetting;
   reg stopKeyEnable;
   reg [FW-1:0] panelFreq;
   reg panelRun;
   reg panelRev;
   reg [FW-1:0] netFreq;
   reg netRun;
   reg netRev;
   reg stopLatch;
   reg paramAccepted;
   reg paramRejected;

   // AHB-Lite address phase capture
   reg wrPending;
   reg [7:0] wrAddr;
   wire addrPhase = hsel & htrans[1] & hready;
   // Zero wait states, response always OKAY; hsize ignored
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPending <= 1'b0;
         wrAddr <= 8'h00;
      end else begin
         wrPending <= addrPhase & hwrite;
         wrAddr <= {haddr[7:2], 2'b00};
      end
   end

   // Write decode in the data phase
   wire wrCtrl = wrPending && (wrAddr == `DOMS_CTRL_OFS);
   wire wrPanelFreq = wrPending && (wrAddr == `DOMS_PANEL_FREQ_OFS);
   wire wrNet = wrPending && (wrAddr == `DOMS_NET_CMD_OFS);
   wire wrParam = wrPending && (wrAddr == `DOMS_PARAM_REQ_OFS);
   wire [2:0] newSetting = hwdata[`DOMS_CTRL_SET_MSB:`DOMS_CTRL_SET_LSB];
   wire [1:0] netMode = hwdata[`DOMS_NET_MODE_MSB:`DOMS_NET_MODE_LSB];
   wire netModeReq = wrNet & hwdata[`DOMS_NET_REQ_BIT];
   // Stopped means no run command leaves the block
   wire stopped = ~runCmd;
   wire runSwitch = (modeSetting == `DOMS_SET_RUNSWITCH);

   wire [FW-1:0] extFreq = inchIn ? inchFreq : msActive ? msFreq : curSel ? curFreq : voltFreq;
   // Both start pins on gives no run
   wire pinRun = fwdIn ^ revIn;
   wire pinRev = revIn & ~fwdIn;

   // Mode moves requested by keys and network
   wire toggleOk = toggleEdge && (runSwitch || ((modeSetting == `DOMS_SET_SWITCH) && stopped));
   wire netOk = netModeReq && (runSwitch ||
      (((modeSetting == `DOMS_SET_SWITCH) || (modeSetting == `DOMS_SET_EXT)) && stopped));
   wire toPanel = toggleOk && (opMode != `DOMS_OP_PANEL) &&
      (runSwitch || opMode == `DOMS_OP_EXT);
   wire toExtByKey = toggleOk && (opMode == `DOMS_OP_PANEL);
   wire toNet = netOk && (netMode == `DOMS_OP_NET) && (opMode != `DOMS_OP_NET) &&
      (runSwitch || opMode == `DOMS_OP_EXT);
   wire toExtByNet = netOk && (netMode == `DOMS_OP_EXT) && (opMode == `DOMS_OP_NET);

   // Command selection per mode
   reg next_run;
   reg next_rev;
   reg [FW-1:0] next_freq;

   always @* begin
      next_run = pinRun;
      next_rev = pinRev;
      next_freq = extFreq;
      case (opMode)
         `DOMS_OP_PANEL: begin
            next_run = panelRun;
            next_rev = panelRev;
            next_freq = panelFreq;
         end
         `DOMS_OP_NET: begin
            next_run = netRun;
            next_rev = netRev;
            next_freq = netFreq;
         end
         default: begin
            if (modeSetting == `DOMS_SET_COMB1) begin
               next_freq = msActive ? msFreq : curSel ? curFreq : panelFreq;
            end else if (modeSetting == `DOMS_SET_COMB2) begin
               next_run = panelRun;
               next_rev = panelRev;
            end
         end
      endcase
      if (stopLatch) begin
         next_run = 1'b0;
      end
   end

   // Mode state, command holders and register writes
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         modeSetting <= `DOMS_SET_RESET;
         opMode <= `DOMS_OP_EXT;
         stopKeyEnable <= `DOMS_STOPEN_RESET;
         panelFreq <= {FW{1'b0}};
         panelRun <= 1'b0;
         panelRev <= 1'b0;
         netFreq <= {FW{1'b0}};
         netRun <= 1'b0;
         netRev <= 1'b0;
         stopLatch <= 1'b0;
         paramAccepted <= 1'b0;
         paramRejected <= 1'b0;
         runCmd <= 1'b0;
         reverseCmd <= 1'b0;
         freqCmd <= {FW{1'b0}};
      end else begin
         runCmd <= next_run;
         reverseCmd <= next_rev;
         freqCmd <= next_freq;

         if (wrCtrl) begin
            stopKeyEnable <= hwdata[`DOMS_CTRL_STOPEN_BIT];
            if (stopped && legalSetting(newSetting)) begin
               modeSetting <= newSetting;
               opMode <= (newSetting == `DOMS_SET_PANEL) ? `DOMS_OP_PANEL : `DOMS_OP_EXT;
            end
         end else if (toPanel) begin
            opMode <= `DOMS_OP_PANEL;
         end else if (toExtByKey || toExtByNet) begin
            opMode <= `DOMS_OP_EXT;
         end else if (toNet) begin
            opMode <= `DOMS_OP_NET;
         end

         // Panel command holder, loaded on a keeping move
         if (toPanel && !wrCtrl) begin
            panelRun <= runCmd;
            panelRev <= reverseCmd;
            panelFreq <= freqCmd;
         end else begin
            if (wrPanelFreq) begin
               panelFreq <= hwdata[FW-1:0];
            end
            if (stopEdge) begin
               panelRun <= 1'b0;
            end else if (runEdge) begin
               panelRun <= 1'b1;
            end
            if (revEdge) begin
               panelRev <= ~panelRev;
            end
         end

         // Network command holder, loaded on a keeping move
         if (toNet && !wrCtrl) begin
            netRun <= runCmd;
            netRev <= reverseCmd;
            netFreq <= freqCmd;
         end else if (wrNet && !netModeReq) begin
            netRun <= hwdata[`DOMS_NET_FWD_BIT] ^ hwdata[`DOMS_NET_REV_BIT];
            netRev <= hwdata[`DOMS_NET_REV_BIT] & ~hwdata[`DOMS_NET_FWD_BIT];
            netFreq <= hwdata[`DOMS_NET_FREQ_LSB+FW-1:`DOMS_NET_FREQ_LSB];
         end

         // stop key latch, set beats release
         if (stopEdge && (stopKeyEnable || opMode == `DOMS_OP_PANEL)) begin
            stopLatch <= 1'b1;
         end else if (!fwdIn && !revIn && !panelRun && !netRun) begin
            stopLatch <= 1'b0;
         end

         if (wrParam) begin
            if (opMode != `DOMS_OP_EXT || hwdata[0]) begin
               paramAccepted <= 1'b1;
               paramRejected <= 1'b0;
            end else begin
               paramAccepted <= 1'b0;
               paramRejected <= 1'b1;
            end
         end
      end
   end

   // Read data, registered in the address phase
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = 32'h00000000;
      if (haddr[7:0] == `DOMS_CTRL_OFS) begin
         next_rdata[`DOMS_CTRL_SET_MSB:`DOMS_CTRL_SET_LSB] = modeSetting;
         next_rdata[`DOMS_CTRL_STOPEN_BIT] = stopKeyEnable;
      end else if (haddr[7:0] == `DOMS_STATUS_OFS) begin
         next_rdata[7:0] = {paramRejected, paramAccepted, stopLatch, reverseCmd, runCmd, 1'b0, opMode};
      end else if (haddr[7:0] == `DOMS_PANEL_FREQ_OFS) begin
         next_rdata[FW-1:0] = panelFreq;
      end else if (haddr[7:0] == `DOMS_NET_CMD_OFS) begin
         next_rdata[`DOMS_NET_FREQ_LSB+FW-1:`DOMS_NET_FREQ_LSB] = netFreq;
         next_rdata[`DOMS_NET_REV_BIT] = netRev & netRun;
         next_rdata[`DOMS_NET_FWD_BIT] = ~netRev & netRun;
      end else if (haddr[7:0] == `DOMS_FREQ_OUT_OFS) begin
         next_rdata[FW-1:0] = freqCmd;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h00000000;
      end else if (addrPhase && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

endmodule // doms_mode_selector
`default_nettype wire

// ==== doms_map.vh ====
/*
 * Register offsets, field positions, reset values and mode codes of the
 * operation mode selector.
 * Assumes a 32-bit AHB-Lite slave port with one aligned word per register.
 */
`ifndef DOMS_MAP_VH
`define DOMS_MAP_VH

// Byte offsets
`define DOMS_CTRL_OFS 8'h00
`define DOMS_STATUS_OFS 8'h04
`define DOMS_PANEL_FREQ_OFS 8'h08
`define DOMS_NET_CMD_OFS 8'h0c
`define DOMS_FREQ_OUT_OFS 8'h10
`define DOMS_PARAM_REQ_OFS 8'h14

// Control register fields
`define DOMS_CTRL_SET_LSB 0
`define DOMS_CTRL_SET_MSB 2
`define DOMS_CTRL_STOPEN_BIT 8

// Network command fields
`define DOMS_NET_MODE_LSB 0
`define DOMS_NET_MODE_MSB 1
`define DOMS_NET_REQ_BIT 2
`define DOMS_NET_FWD_BIT 3
`define DOMS_NET_REV_BIT 4
`define DOMS_NET_FREQ_LSB 16

// Reset values
`define DOMS_SET_RESET 3'h0
`define DOMS_STOPEN_RESET 1'b1

// Operation mode setting values
`define DOMS_SET_SWITCH 3'h0
`define DOMS_SET_PANEL 3'h1
`define DOMS_SET_EXT 3'h2
`define DOMS_SET_COMB1 3'h3
`define DOMS_SET_COMB2 3'h4
`define DOMS_SET_RUNSWITCH 3'h6

// Current operation mode codes
`define DOMS_OP_EXT 2'h0
`define DOMS_OP_PANEL 2'h1
`define DOMS_OP_NET 2'h2

`endif

// ==== doms_field_model.sv ====
/* Far-side model: panel keys, terminal pins and frequency sources.
   Assumes the bench calls its tasks; every change follows a rising clock edge. */
`default_nettype none
module doms_field_model (
   input wire logic clk,
   output logic [3:0] keys,
   output logic [4:0] pins,
   output logic [15:0] fVolt,
   output logic [15:0] fCur,
   output logic [15:0] fMs,
   output logic [15:0] fInch
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      keys = '0;
      pins = '0;
      fVolt = 16'h1111;
      fCur = 16'h2222;
      fMs = 16'h3333;
      fInch = 16'h4444;
   end
   task automatic press(input int k);
      @(posedge clk) keys[k] <= 1'b1;
      repeat (4) @(posedge clk);
      keys[k] <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic setPins(input logic [4:0] v);
      @(posedge clk) pins <= v;
      repeat (8) @(posedge clk);
   endtask
   task automatic setFreq(input int i, input logic [15:0] v);
      @(posedge clk);
      case (i)
         0: fVolt <= v;
         1: fCur <= v;
         2: fMs <= v;
         default: fInch <= v;
      endcase
      repeat (8) @(posedge clk);
   endtask
endmodule // doms_field_model
`default_nettype wire

// ==== doms_mode_properties.sv ====
/* Port checker for the mode selector.
   Assumes it is bound to the selector top and sees only its ports. */
`default_nettype none
module doms_mode_props #(
   parameter FW = 16
) (
   input wire clk,
   input wire rst_b,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire panelToggleKey,
   input wire panelStopKey,
   input wire [1:0] opMode,
   input wire runCmd,
   input wire [FW-1:0] freqCmd
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire rdReq = hsel && htrans[1] && !hwrite && hready;
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_reset_ext: assert property ($rose(rst_b) |-> opMode == 2'h0 && !runCmd && freqCmd == '0)
      else $error("not external and idle after reset");
   a_rdata_holds: assert property (!rdReq |=> $stable(hrdata)) else $error("read data moved");
   a_mode_cause: assert property ($changed(opMode) |-> $past(panelToggleKey, 3) || $past(htrans[1], 2))
      else $error("mode changed without a cause");
   a_toggle_wait: assert property ($rose(panelToggleKey) |=> $stable(opMode) [*2])
      else $error("mode moved too early");
   a_stop_halts: assert property ($rose(panelStopKey) |-> ##[1:6] !runCmd) else $error("stop ignored");
   a_stop_keeps: assert property (panelStopKey [*4] |=> !runCmd) else $error("run under stop");
   a_keep_carry: assert property ($changed(opMode) && opMode != 2'h0 && runCmd
      |=> $stable(freqCmd) && $stable(runCmd)) else $error("commands not carried over");
   c_net_run: cover property (opMode == 2'h2 && runCmd);
   c_panel_run: cover property (opMode == 2'h1 && runCmd);
   c_stop: cover property ($rose(panelStopKey) ##5 !runCmd);
endmodule // doms_mode_props
bind doms_mode_selector doms_mode_props #(.FW(FW)) chk (.clk(clk), .rst_b(rst_b), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .panelToggleKey(panelToggleKey), .panelStopKey(panelStopKey), .opMode(opMode), .runCmd(runCmd),
   .freqCmd(freqCmd));
`default_nettype wire

// ==== tb_top.sv ====
/* Self-checking bench: AHB-Lite master tasks and one task per scenario.
   Assumes the field model drives keys and pins. */
`default_nettype none
`include "doms_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, hsel, hwrite;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, rv;
   wire [31:0] hrdata;
   wire hreadyout, hresp, runCmd, reverseCmd;
   wire [1:0] opMode;
   wire [15:0] freqCmd, fV, fC, fM, fI;
   wire [3:0] keys;
   wire [4:0] pins;
   int err_total, cmp_count, cyc;
   doms_field_model fm (.clk(clk), .keys(keys), .pins(pins), .fVolt(fV), .fCur(fC), .fMs(fM), .fInch(fI));
   doms_mode_selector uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .forwardStartInput(pins[0]), .reverseStartInput(pins[1]),
      .currentInputSelect(pins[2]), .multiSpeedActive(pins[3]), .inchingInput(pins[4]),
      .analogVoltageFreq(fV), .analogCurrentFreq(fC), .multiSpeedFreq(fM), .inchingFreq(fI),
      .panelToggleKey(keys[0]), .panelRunKey(keys[1]), .panelStopKey(keys[2]), .panelReverseKey(keys[3]),
      .opMode(opMode), .runCmd(runCmd), .reverseCmd(reverseCmd), .freqCmd(freqCmd));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rv = hrdata;
   endtask
   task automatic setm(input logic [31:0] s);
      xfer(1'b1, `DOMS_CTRL_OFS, 32'h100 | s);
   endtask
   task automatic st(input logic [1:0] m, input logic r, input logic [15:0] f);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("opMode", opMode, m);
      chk("runCmd", runCmd, r);
      if (r)
         chk("freqCmd", freqCmd, f);
   endtask
   task automatic fsrc(input int i, input logic [15:0] v, input logic [15:0] keep);
      fm.setFreq(i, v);
      st(2'h0, 1'b1, v);
      fm.setFreq(i, keep);
   endtask
   task automatic prm(input logic [31:0] d, input logic [1:0] e);
      xfer(1'b1, `DOMS_PARAM_REQ_OFS, d);
      xfer(1'b0, `DOMS_STATUS_OFS, 0);
      chk("paramWrite", rv[7:6], e);
   endtask
   task automatic s_reset_toggle();
      xfer(1'b0, `DOMS_CTRL_OFS, 0);
      chk("ctrl", rv, 32'h100);
      xfer(1'b0, 32'h20, 0);
      chk("unmapped", rv, 0);
      st(2'h0, 1'b0, 0);
      fm.press(0);
      st(2'h1, 1'b0, 0);
      prm(0, 2'h1);
      fm.press(0);
      st(2'h0, 1'b0, 0);
      prm(0, 2'h2);
      prm(1, 2'h1);
   endtask
   task automatic s_ext();
      fm.setPins(5'h01);
      st(2'h0, 1'b1, 16'h1111);
      chk("reverseCmd", reverseCmd, 0);
      xfer(1'b0, `DOMS_FREQ_OUT_OFS, 0);
      chk("freqOut", rv, 32'h1111);
      fsrc(0, 16'h9e01, 16'h1111);
      fm.setPins(5'h09);
      st(2'h0, 1'b1, 16'h3333);
      fsrc(2, 16'h7c35, 16'h3333);
      fm.setPins(5'h19);
      st(2'h0, 1'b1, 16'h4444);
      fsrc(3, 16'hb00f, 16'h4444);
      fm.setPins(5'h06);
      st(2'h0, 1'b1, 16'h2222);
      chk("reverseCmd", reverseCmd, 1);
      fsrc(1, 16'hc3d4, 16'h2222);
      setm(1);
      xfer(1'b0, `DOMS_CTRL_OFS, 0);
      chk("ctrl", rv, 32'h100);
      fm.press(2);
      st(2'h0, 1'b0, 0);
      fm.setPins(0);
   endtask
   task automatic s_fixed();
      setm(2);
      fm.press(0);
      st(2'h0, 1'b0, 0);
      setm(1);
      fm.press(0);
      xfer(1'b1, `DOMS_NET_CMD_OFS, 32'h6);
      st(2'h1, 1'b0, 0);
      setm(3);
      xfer(1'b1, `DOMS_PANEL_FREQ_OFS, 32'h0123);
      fm.setPins(5'h01);
      st(2'h0, 1'b1, 16'h0123);
      fm.setPins(5'h05);
      st(2'h0, 1'b1, 16'h2222);
      fm.setPins(5'h0d);
      fm.press(0);
      st(2'h0, 1'b1, 16'h3333);
      fm.setPins(0);
      setm(4);
      fm.setPins(5'h01);
      st(2'h0, 1'b0, 0);
      fm.setPins(0);
      fm.press(1);
      st(2'h0, 1'b1, 16'h1111);
      fm.press(3);
      st(2'h0, 1'b1, 16'h1111);
      chk("reverseCmd", reverseCmd, 1);
      fm.press(2);
      st(2'h0, 1'b0, 0);
   endtask
   task automatic s_switch();
      setm(6);
      fm.setPins(5'h01);
      fm.press(0);
      st(2'h1, 1'b1, 16'h1111);
      fm.setPins(0);
      st(2'h1, 1'b1, 16'h1111);
      xfer(1'b1, `DOMS_NET_CMD_OFS, 32'h6);
      st(2'h2, 1'b1, 16'h1111);
      fm.press(0);
      st(2'h1, 1'b1, 16'h1111);
      fm.press(0);
      st(2'h0, 1'b0, 0);
      fm.setPins(5'h02);
      xfer(1'b1, `DOMS_NET_CMD_OFS, 32'h6);
      fm.setPins(0);
      st(2'h2, 1'b1, 16'h1111);
      xfer(1'b1, `DOMS_NET_CMD_OFS, 32'h4);
      st(2'h0, 1'b0, 0);
      xfer(1'b0, `DOMS_NET_CMD_OFS, 0);
      chk("netHold", rv, 32'h11110010);
      xfer(1'b0, `DOMS_PANEL_FREQ_OFS, 0);
      chk("panelHold", rv, 32'h1111);
      @(posedge clk) rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      st(2'h0, 1'b0, 0);
      xfer(1'b0, `DOMS_NET_CMD_OFS, 0);
      chk("netHold", rv, 0);
      xfer(1'b0, `DOMS_PANEL_FREQ_OFS, 0);
      chk("panelHold", rv, 0);
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = '0;
      hwdata = '0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      s_reset_toggle();
      s_ext();
      s_fixed();
      s_switch();
      final_report();
   end
endmodule // tb_top
`default_nettype wire
